// [hdl/input_threshold_and_current_offset_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "thr_cfg.svh"

module input_threshold_and_current_offset_regs
    import thr_pkg::*;
#(
    parameter int IW = 12 // current width, quarter-amp counts
)(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire reg_req_s req_i, // register access
    input wire nvm_img_s nvm_i, // restore image
    input wire logic nvm_restore_i, // one-cycle restore pulse
    input wire logic nvm_store_i, // one-cycle store pulse
    input wire logic enable_pin_i, // asynchronous enable pin
    input wire decivolt_t vin_dv_i, // sensed input, 0.1 V units
    input wire logic [IW-1:0] iout_meas_i, // measured current
    input wire logic uv_clear_i, // clears the flag
    output logic [15:0] rd_data_o,
    output logic rd_ack_o,
    output logic conv_on_o,
    output logic uv_flag_o,
    output logic uv_masked_o,
    output decivolt_t start_dv_o,
    output decivolt_t stop_dv_o,
    output logic [IW-1:0] iout_rpt_o
);

    // -------------------------------------------------------------
    // reset release and pin synchroniser
    // -------------------------------------------------------------
    logic rst_q1_r; // first release stage
    logic rst_n_r; // released reset used by all logic
    logic en_q1_r; // first enable stage, read by en_r only
    logic en_r; // synchronised enable

    // release is synchronous so no flop leaves reset on its own edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n_r <= rst_q1_r;
        end
    end

    // enable pin arrives from outside the clock domain
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            en_q1_r <= 1'b0;
            en_r <= 1'b0;
        end else begin
            en_q1_r <= enable_pin_i;
            en_r <= en_q1_r;
        end
    end

    // -------------------------------------------------------------
    // writable mantissas
    // -------------------------------------------------------------
    logic [3:0] start_man_r; // start threshold mantissa
    logic [3:0] stop_man_r; // stop threshold mantissa
    logic [3:0] off_man_r; // signed offset mantissa
    logic wr_start; // write hits start register
    logic wr_stop; // write hits stop register
    logic wr_off; // write hits offset register

    assign wr_start = req_i.wr && (req_i.cmd == `CMD_START);
    assign wr_stop = req_i.wr && (req_i.cmd == `CMD_STOP);
    assign wr_off = req_i.wr && (req_i.cmd == `CMD_OFFSET);

    // only bits 3:0 are kept; upper bits of the write word are dropped
    // a host write in the restore cycle wins, being the newer value
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            start_man_r <= `MAN_RST;
            stop_man_r <= `MAN_RST;
            off_man_r <= `MAN_RST;
        end else begin
            if (nvm_restore_i) begin
                start_man_r <= nvm_i.start_man;
                stop_man_r <= nvm_i.stop_man;
                off_man_r <= nvm_i.off_man;
            end
            if (wr_start) begin
                start_man_r <= req_i.data[`MAN_MSB:0];
            end
            if (wr_stop) begin
                stop_man_r <= req_i.data[`MAN_MSB:0];
            end
            if (wr_off) begin
                off_man_r <= req_i.data[`MAN_MSB:0];
            end
        end
    end

    // -------------------------------------------------------------
    // register read path
    // -------------------------------------------------------------
    logic [15:0] rd_word; // word selected by the command

    // fixed fields are rebuilt on every read, never stored
    always_comb begin
        case (req_i.cmd)
            `CMD_START: begin
                rd_word = {`EXP_VOLT, `FILL_ZERO, start_man_r};
            end
            `CMD_STOP: begin
                rd_word = {`EXP_VOLT, `FILL_ZERO, stop_man_r};
            end
            `CMD_OFFSET: begin
                rd_word = {`EXP_QUART, {7{off_man_r[`MAN_MSB]}}, off_man_r};
            end
            default: begin
                rd_word = `RD_NONE; // unknown code reads as zero
            end
        endcase
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_data_o <= `RD_NONE;
            rd_ack_o <= 1'b0;
        end else begin
            rd_ack_o <= req_i.rd;
            if (req_i.rd) begin
                rd_data_o <= rd_word;
            end
        end
    end

    // -------------------------------------------------------------
    // threshold decode
    // -------------------------------------------------------------
    decivolt_t start_dv; // decoded start level
    decivolt_t stop_dv; // decoded stop level

    threshold_decode u_start_dec (
        .man_i(start_man_r),
        .stop_tbl_i(1'b0),
        .dv_o(start_dv)
    );

    threshold_decode u_stop_dec (
        .man_i(stop_man_r),
        .stop_tbl_i(1'b1),
        .dv_o(stop_dv)
    );

    // registered copies drive both the ports and the comparators
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            start_dv_o <= `DV_ON_LOW;
            stop_dv_o <= `DV_OFF_LOW;
        end else begin
            start_dv_o <= start_dv;
            stop_dv_o <= stop_dv;
        end
    end

    // -------------------------------------------------------------
    // conversion control
    // -------------------------------------------------------------
    conv_state_e state_r; // conversion state
    conv_state_e state_nxt; // next conversion state
    logic above_start; // input reached start level
    logic below_stop; // input under stop level
    logic uv_event; // unmasked undervoltage stop

    assign above_start = vin_dv_i >= start_dv_o;
    assign below_stop = vin_dv_i < stop_dv_o;
    assign uv_event = (state_r == CONV_ON) && en_r && below_stop && !uv_masked_o;

    // stop above start is not checked; nothing warns the host of chatter
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CONV_OFF: begin
                if (en_r && above_start) begin
                    state_nxt = CONV_ON;
                end
            end
            CONV_ON: begin
                if (!en_r || below_stop) begin
                    state_nxt = CONV_OFF;
                end
            end
            default: begin
                state_nxt = CONV_OFF;
            end
        endcase
    end

    // state and its output copy move together
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= CONV_OFF;
            conv_on_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            conv_on_o <= (state_nxt == CONV_ON);
        end
    end

    // -------------------------------------------------------------
    // undervoltage mask and flag
    // -------------------------------------------------------------
    // mask is set only by reset; enable and memory pulses never touch it
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            uv_masked_o <= 1'b1;
        end else if (vin_dv_i > start_dv_o) begin
            uv_masked_o <= 1'b0;
        end
    end

    // sticky flag; a new event in the clear cycle wins
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            uv_flag_o <= 1'b0;
        end else if (uv_event) begin
            uv_flag_o <= 1'b1;
        end else if (uv_clear_i) begin
            uv_flag_o <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // current report with offset
    // -------------------------------------------------------------
    logic signed [IW+1:0] iout_sum; // measured plus signed offset
    logic [IW-1:0] iout_clip; // clamped result

    assign iout_sum = $signed({2'b00, iout_meas_i})
        + $signed({{(IW-2){off_man_r[`MAN_MSB]}}, off_man_r});

    // upper end saturates too, so a full-scale reading never wraps
    always_comb begin
        if (iout_sum < 0) begin
            iout_clip = '0;
        end else if (iout_sum[IW]) begin
            iout_clip = '1;
        end else begin
            iout_clip = iout_sum[IW-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            iout_rpt_o <= '0;
        end else begin
            iout_rpt_o <= iout_clip;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_r);

    sequence rd_start_s;
        req_i.rd && req_i.cmd == `CMD_START;
    endsequence

    sequence rd_off_s;
        req_i.rd && req_i.cmd == `CMD_OFFSET;
    endsequence

    sequence man_top_s;
        start_man_r >= `MAN_TOP ##1 $stable(start_man_r);
    endsequence

    conv_start_a: assert property (
        state_r == CONV_OFF && en_r && above_start |=> conv_on_o)
        else $error("conversion did not start at threshold");

    thr_fixed_a: assert property (
        rd_start_s |=> rd_ack_o && rd_data_o[`EXP_MSB:`EXP_LSB] == `EXP_VOLT
            && rd_data_o[`MAN_MSB:0] == $past(start_man_r))
        else $error("start word exponent or mantissa wrong");

    thr_fill_a: assert property (
        rd_ack_o && $past(req_i.cmd) == `CMD_STOP
            |-> rd_data_o[`FILL_MSB:`FILL_LSB] == `FILL_ZERO)
        else $error("stop word fill not zero");

    man_write_a: assert property (
        wr_stop |=> stop_man_r == $past(req_i.data[`MAN_MSB:0]))
        else $error("stop mantissa not stored");

    start_dec_a: assert property (
        man_top_s |-> start_dv_o == `DV_ON_MAX)
        else $error("start decode top entry wrong");

    stop_dec_a: assert property (
        stop_man_r < `MAN_LOW ##1 $stable(stop_man_r) |-> stop_dv_o == `DV_OFF_LOW)
        else $error("stop decode low entry wrong");

    uv_mask_a: assert property (
        uv_masked_o |-> !uv_flag_o)
        else $error("flag set while masked");

    mask_keep_a: assert property (
        !uv_masked_o |=> !uv_masked_o)
        else $error("mask came back without reset");

    // store and restore pulses leave the mask alone unless the input crosses
    mask_nvm_a: assert property (
        (nvm_store_i || nvm_restore_i) && vin_dv_i <= start_dv_o
            |=> uv_masked_o == $past(uv_masked_o))
        else $error("memory pulse changed the mask");

    uv_stop_a: assert property (
        uv_event |=> !conv_on_o && uv_flag_o)
        else $error("undervoltage did not stop and flag");

    cur_sum_a: assert property (
        iout_sum >= 0 && !iout_sum[IW] |=> iout_rpt_o == $past(iout_sum[IW-1:0]))
        else $error("current report not offset");

    cur_clamp_a: assert property (
        iout_sum < 0 |=> iout_rpt_o == '0)
        else $error("negative current not clamped");

    off_word_a: assert property (
        rd_off_s |=> rd_data_o[`EXP_MSB:`EXP_LSB] == `EXP_QUART
            && rd_data_o[`FILL_MSB:`FILL_LSB] == {7{rd_data_o[`MAN_MSB]}})
        else $error("offset word exponent or sign wrong");

endmodule : input_threshold_and_current_offset_regs
`default_nettype wire

// [hdl/thr_cfg.svh]
`ifndef THR_CFG_SVH
`define THR_CFG_SVH
// Function
// - start threshold at 35h gates conversion start
// - threshold exponent fixed zero, one volt step
// - threshold bits 10:4 read as zero
// - threshold mantissa writable, restored from memory
// - start mantissa decodes to its volt table
// - stop mantissa decodes to its volt table
// - undervoltage flag masked until first start crossing
// - enable toggles and store/restore keep mask
// - stop threshold at 36h stops, sets flag
// - signed offset at 39h added to current
// - negative current result clamps to zero
// - offset exponent fixed minus two, quarter amp
// - offset bits 10:4 copy mantissa sign
// - offset mantissa spans plus 1.75 to minus 2

// -------------------------------------------------------------
// command codes
// -------------------------------------------------------------
`define CMD_START 8'h35
`define CMD_STOP 8'h36
`define CMD_OFFSET 8'h39

// -------------------------------------------------------------
// word layout and fixed field values
// -------------------------------------------------------------
`define EXP_LSB 11
`define EXP_MSB 15
`define FILL_LSB 4
`define FILL_MSB 10
`define MAN_MSB 3
`define EXP_VOLT 5'h00
`define EXP_QUART 5'h1e
`define FILL_ZERO 7'h00
`define MAN_RST 4'h0
`define RD_NONE 16'h0000

// -------------------------------------------------------------
// mantissa breakpoints of the decode tables
// -------------------------------------------------------------
`define MAN_TOP 4'ha
`define MAN_SIX 4'h6
`define MAN_MID 4'h5
`define MAN_LOW 4'h3

// -------------------------------------------------------------
// decoded thresholds in tenths of a volt
// -------------------------------------------------------------
`define DV_PER_VOLT 8'h0a
`define DV_HALF 8'h05
`define DV_ON_MAX 8'h64
`define DV_ON_MID 8'h26
`define DV_ON_LOW 8'h19
`define DV_OFF_MAX 8'h5f
`define DV_OFF_FIVE 8'h2a
`define DV_OFF_MID 8'h24
`define DV_OFF_LOW 8'h17

`endif

// [hdl/thr_pkg.sv]
package thr_pkg;

    // -------------------------------------------------------------
    // register access request, one command per cycle
    // -------------------------------------------------------------
    typedef struct packed {
        logic wr; // write strobe, one cycle
        logic rd; // read strobe, one cycle
        logic [7:0] cmd; // command code
        logic [15:0] data; // write word
    } reg_req_s;

    // image restored from non-volatile memory
    typedef struct packed {
        logic [3:0] start_man;
        logic [3:0] stop_man;
        logic [3:0] off_man;
    } nvm_img_s;

    // conversion state
    typedef enum logic {
        CONV_OFF = 1'b0,
        CONV_ON = 1'b1
    } conv_state_e;

    // voltage in tenths of a volt
    typedef logic [7:0] decivolt_t;

endpackage : thr_pkg

// [hdl/threshold_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "thr_cfg.svh"

// maps a 4-bit threshold mantissa to tenths of a volt
module threshold_decode
    import thr_pkg::*;
(
    input wire logic [3:0] man_i,
    input wire logic stop_tbl_i,
    output decivolt_t dv_o
);

    // -------------------------------------------------------------
    // table lookup
    // -------------------------------------------------------------
    // mantissa is treated as unsigned: the tables cover 0..15
    always_comb begin
        if (!stop_tbl_i) begin
            if (man_i >= `MAN_TOP) begin
                dv_o = `DV_ON_MAX;
            end else if (man_i >= `MAN_MID) begin
                dv_o = 8'({4'h0, man_i} * `DV_PER_VOLT);
            end else if (man_i >= `MAN_LOW) begin
                dv_o = `DV_ON_MID;
            end else begin
                dv_o = `DV_ON_LOW;
            end
        end else begin
            if (man_i >= `MAN_TOP) begin
                dv_o = `DV_OFF_MAX;
            end else if (man_i >= `MAN_SIX) begin
                // half a volt under the whole volt figure
                dv_o = 8'({4'h0, man_i} * `DV_PER_VOLT - `DV_HALF);
            end else if (man_i == `MAN_MID) begin
                dv_o = `DV_OFF_FIVE;
            end else if (man_i >= `MAN_LOW) begin
                dv_o = `DV_OFF_MID;
            end else begin
                dv_o = `DV_OFF_LOW;
            end
        end
    end

endmodule : threshold_decode
`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------
// host on the management side: issues one word access at a time
// -------------------------------------------------------------
module host_model
    import thr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rd_ack_i, // answer strobe from the block
    input wire logic [15:0] rd_data_i, // answer word
    output reg_req_s req_o // request towards the block
);
    // idle request carries junk, so a stale value is never trusted
    initial begin
        req_o = '{wr: 1'b0, rd: 1'b0, cmd: 8'hff, data: 16'hffff};
    end

    // launch after a falling edge, hold across one taking edge, release
    task automatic access(input logic wr, input logic rd, input logic [7:0] cmd,
                          input logic [15:0] data);
        @(negedge clock_i);
        req_o = '{wr: wr, rd: rd, cmd: cmd, data: data};
        @(negedge clock_i);
        // released lines show the inverse, not the last value
        req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, data: ~data};
    endtask : access

    task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
        access(1'b1, 1'b0, cmd, data);
    endtask : write_word

    // answer is registered on the taking edge; the ack stands one cycle, the data until the next read
    task automatic read_word(input logic [7:0] cmd, output logic ack,
                             output logic [15:0] word);
        // the release edge lies inside the one cycle the answer stands
        access(1'b0, 1'b1, cmd, 16'h0000);
        ack = rd_ack_i;
        word = rd_data_i;
    endtask : read_word
endmodule : host_model

`default_nettype wire

// [sim/test_input_threshold_and_current_offset_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// one compare: counts, and reports a mismatch at once
`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end

module test_input_threshold_and_current_offset_regs
    import thr_pkg::*;
;
    // -------------------------------------------------------------
    // stimulus and observed signals
    // -------------------------------------------------------------
    logic clock;
    logic rst_n;
    reg_req_s req;
    nvm_img_s nvm;
    logic nvm_restore, nvm_store, enable_pin, uv_clear;
    decivolt_t vin_dv, start_dv, stop_dv;
    logic [11:0] iout_meas, iout_rpt;
    logic [15:0] rd_data;
    logic rd_ack, conv_on, uv_flag, uv_masked;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    input_threshold_and_current_offset_regs #(.IW(12)) i_dut (
        .clock_i(clock), .rst_n_i(rst_n), .req_i(req), .nvm_i(nvm),
        .nvm_restore_i(nvm_restore), .nvm_store_i(nvm_store),
        .enable_pin_i(enable_pin), .vin_dv_i(vin_dv), .iout_meas_i(iout_meas),
        .uv_clear_i(uv_clear), .rd_data_o(rd_data), .rd_ack_o(rd_ack),
        .conv_on_o(conv_on), .uv_flag_o(uv_flag), .uv_masked_o(uv_masked),
        .start_dv_o(start_dv), .stop_dv_o(stop_dv), .iout_rpt_o(iout_rpt)
    );

    host_model i_host (
        .clock_i(clock), .rd_ack_i(rd_ack), .rd_data_i(rd_data), .req_o(req)
    );

    // -------------------------------------------------------------
    // expectations and helpers
    // -------------------------------------------------------------
    function automatic decivolt_t start_exp(input int m);
        if (m >= 10) return 8'h64;
        if (m >= 5) return 8'(m * 10);
        if (m >= 3) return 8'h26;
        return 8'h19;
    endfunction : start_exp

    function automatic decivolt_t stop_exp(input int m);
        if (m >= 10) return 8'h5f;
        if (m >= 6) return 8'(m * 10 - 5);
        if (m == 5) return 8'h2a;
        if (m >= 3) return 8'h24;
        return 8'h17;
    endfunction : stop_exp

    // a write lands on the mantissa, then on the decoded outputs
    task automatic settle();
        repeat (2) @(negedge clock);
    endtask : settle

    task automatic reg_check(input logic [7:0] cmd, input logic [15:0] exp);
        logic ack;
        logic [15:0] word;
        i_host.read_word(cmd, ack, word);
        `CHK("rd_ack", 1'b1, ack)
        `CHK("rd_data", exp, word)
    endtask : reg_check

    // enable sync plus one register stage fits well inside four cycles
    task automatic step(input logic en, input decivolt_t vin);
        @(negedge clock);
        enable_pin = en;
        vin_dv = vin;
        repeat (4) @(negedge clock);
    endtask : step

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic test_reset();
        `CHK("start_dv", 8'h19, start_dv)
        `CHK("stop_dv", 8'h17, stop_dv)
        `CHK("uv_masked", 1'b1, uv_masked)
        reg_check(8'h35, 16'h0000);
        reg_check(8'h36, 16'h0000);
        reg_check(8'h39, 16'hf000);
        reg_check(8'h37, 16'h0000);
        $display("test reset done");
    endtask : test_reset

    // every mantissa, with junk in the read-only bits of each write
    task automatic test_thresholds();
        for (int m = 0; m < 16; m++) begin
            i_host.write_word(8'h35, {12'hfff, 4'(m)});
            i_host.write_word(8'h36, {12'hfff, 4'(m)});
            settle();
            `CHK("start_dv", start_exp(m), start_dv)
            `CHK("stop_dv", stop_exp(m), stop_dv)
            reg_check(8'h35, {12'h000, 4'(m)});
            reg_check(8'h36, {12'h000, 4'(m)});
        end
        $display("test thresholds done");
    endtask : test_thresholds

    // small measured value so the negative end must clamp
    task automatic test_offset();
        logic [3:0] man;
        int sum;
        iout_meas = 12'h003;
        for (int m = 0; m < 16; m++) begin
            man = 4'(m);
            i_host.write_word(8'h39, {man[3] ? 12'h000 : 12'hfff, man});
            settle();
            sum = 3 + (man[3] ? m - 16 : m);
            `CHK("iout_rpt", 12'(sum < 0 ? 0 : sum), iout_rpt)
            reg_check(8'h39, {5'h1e, {7{man[3]}}, man});
        end
        iout_meas = 12'hfff;
        i_host.write_word(8'h39, 16'h0007);
        settle();
        `CHK("iout_rpt", 12'hfff, iout_rpt)
        $display("test offset done");
    endtask : test_offset

    // restore and store together must not disturb the mask
    task automatic test_restore();
        @(negedge clock);
        nvm = '{start_man: 4'h6, stop_man: 4'h5, off_man: 4'h8};
        nvm_restore = 1'b1;
        nvm_store = 1'b1;
        @(negedge clock);
        nvm_restore = 1'b0;
        nvm_store = 1'b0;
        settle();
        `CHK("start_dv", 8'h3c, start_dv)
        `CHK("stop_dv", 8'h2a, stop_dv)
        `CHK("uv_masked", 1'b1, uv_masked)
        `CHK("iout_rpt", 12'hff7, iout_rpt)
        reg_check(8'h39, 16'hf7f8);
        $display("test restore done");
    endtask : test_restore

    // start 6.0 V above stop 4.2 V, as the host should keep them
    task automatic test_conversion();
        step(1'b1, 8'h32);
        `CHK("conv_on", 1'b0, conv_on)
        step(1'b1, 8'h1e);
        `CHK("uv_flag", 1'b0, uv_flag)
        step(1'b1, 8'h3c);
        `CHK("conv_on", 1'b1, conv_on)
        `CHK("uv_masked", 1'b1, uv_masked)
        step(1'b1, 8'h3d);
        `CHK("uv_masked", 1'b0, uv_masked)
        step(1'b0, 8'h3d);
        `CHK("conv_on", 1'b0, conv_on)
        `CHK("uv_flag", 1'b0, uv_flag)
        `CHK("uv_masked", 1'b0, uv_masked)
        step(1'b1, 8'h3d);
        `CHK("conv_on", 1'b1, conv_on)
        step(1'b1, 8'h29);
        `CHK("conv_on", 1'b0, conv_on)
        `CHK("uv_flag", 1'b1, uv_flag)
        @(negedge clock);
        uv_clear = 1'b1;
        @(negedge clock);
        uv_clear = 1'b0;
        @(negedge clock);
        `CHK("uv_flag", 1'b0, uv_flag)
        $display("test conversion done");
    endtask : test_conversion

    // -------------------------------------------------------------
    // clock, watchdog and main sequence
    // -------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // a few hundred cycles are expected; this ceiling means a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        rst_n = 1'b0;
        nvm = '{start_man: 4'h0, stop_man: 4'h0, off_man: 4'h0};
        nvm_restore = 1'b0;
        nvm_store = 1'b0;
        enable_pin = 1'b0;
        uv_clear = 1'b0;
        vin_dv = 8'h00;
        iout_meas = 12'h000;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        // internal reset needs two edges, first request on the sixth
        repeat (4) @(negedge clock);
        test_reset();
        test_thresholds();
        test_offset();
        test_restore();
        test_conversion();
        close_out();
    end
endmodule : test_input_threshold_and_current_offset_regs

`default_nettype wire
